// >>> rtl/fbp_pkg.sv
// constants and types shared by the flash block protection logic
package fbp_pkg;
   localparam int FLASH_BYTES = 131072;
   localparam int WORD_BYTES = 4;
   localparam int FLASH_WORDS = FLASH_BYTES / WORD_BYTES;
   localparam int WADDR_W = 15;
   localparam int DATA_W = 32;
   localparam int BLK_BYTES = 1024;
   localparam int BLK_WORDS = BLK_BYTES / WORD_BYTES;
   localparam int BLK_LSB = 8;
   localparam int BLK_W = 7;
   localparam int WCNT_W = 8;
   localparam int UNIT_BYTES = 2048;
   localparam int UNIT_LSB = 9;
   localparam int UNIT_W = 6;
   localparam int NUM_UNITS = FLASH_BYTES / UNIT_BYTES;
   localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
   localparam logic [DATA_W-1:0] DENY_WORD = 32'h00000000;
   localparam logic [WCNT_W-1:0] WCNT_LAST = 8'hFF;
   localparam logic [WCNT_W-1:0] WCNT_RST = 8'h00;
   typedef logic [WADDR_W-1:0] fbp_waddr_t;
   typedef logic [DATA_W-1:0] fbp_word_t;
   typedef logic [NUM_UNITS-1:0] fbp_umask_t;
   typedef enum logic [0:0] {FBP_IDLE, FBP_ERASE} fbp_state_t;
endpackage : fbp_pkg

// >>> rtl/fbp_chk_if.sv
// carries protection lookups between the access logic and the checker
`timescale 1ns/1ps
interface fbp_chk_if;
   import fbp_pkg::*;
   logic [UNIT_W-1:0] fetch_unit;
   logic [UNIT_W-1:0] data_unit;
   logic [UNIT_W-1:0] cmd_unit;
   logic fetch_ok;
   logic data_ok;
   logic cmd_ok;
   modport req (output fetch_unit, output data_unit, output cmd_unit,
      input fetch_ok, input data_ok, input cmd_ok);
   modport chk (input fetch_unit, input data_unit, input cmd_unit,
      output fetch_ok, output data_ok, output cmd_ok);
endinterface : fbp_chk_if

// >>> rtl/fbp_prot_chk.sv
// protection lookup for fetch, data/debug read and erase/program
`timescale 1ns/1ps
module fbp_prot_chk (
   input wire fbp_pkg::fbp_umask_t i_ro,
   input wire fbp_pkg::fbp_umask_t i_xo,
   fbp_chk_if.chk chk
);
   import fbp_pkg::*;
   always_comb begin
      // fetches pass every setting; execute-only hides data from data and debug reads
      chk.fetch_ok = 1'b1;
      chk.data_ok = !i_xo[chk.data_unit];
      // either protection setting freezes the unit's contents
      chk.cmd_ok = !(i_ro[chk.cmd_unit] || i_xo[chk.cmd_unit]);
   end
endmodule : fbp_prot_chk

// >>> rtl/fbp_top.sv
// flash array with block erase, word program and per-unit protection
`timescale 1ns/1ps
module fbp_top (
   input wire logic I_CLK,
   input wire logic I_RESET,
   input wire fbp_pkg::fbp_umask_t I_PROT_RO,
   input wire fbp_pkg::fbp_umask_t I_PROT_XO,
   input wire logic I_FETCH_REQ,
   input wire fbp_pkg::fbp_waddr_t I_FETCH_ADDR,
   output logic O_FETCH_VALID,
   output fbp_pkg::fbp_word_t O_FETCH_RDATA,
   input wire logic I_DATA_REQ,
   input wire logic I_DATA_DBG,
   input wire fbp_pkg::fbp_waddr_t I_DATA_ADDR,
   output logic O_DATA_VALID,
   output logic O_DATA_DENY,
   output fbp_pkg::fbp_word_t O_DATA_RDATA,
   input wire logic I_CMD_ERASE,
   input wire logic I_CMD_PGM,
   input wire fbp_pkg::fbp_waddr_t I_CMD_ADDR,
   input wire fbp_pkg::fbp_word_t I_CMD_WDATA,
   output logic O_BUSY,
   output logic O_CMD_DONE,
   output logic O_CMD_DENY,
   input wire logic I_VIOL_CLR,
   output logic O_VIOLATION
);
   import fbp_pkg::*;

   fbp_word_t mem [FLASH_WORDS];

   fbp_chk_if chk_if ();

   fbp_prot_chk u_chk (
      .i_ro(I_PROT_RO),
      .i_xo(I_PROT_XO),
      .chk(chk_if)
   );

   fbp_state_t state_r, state_nxt;
   logic [WCNT_W-1:0] wcnt_r, wcnt_nxt;
   logic [BLK_W-1:0] blk_r, blk_nxt;
   logic fetch_valid_r, fetch_valid_nxt;
   fbp_word_t fetch_rdata_r, fetch_rdata_nxt;
   logic data_valid_r, data_valid_nxt;
   logic data_deny_r, data_deny_nxt;
   fbp_word_t data_rdata_r, data_rdata_nxt;
   logic done_r, done_nxt;
   logic cdeny_r, cdeny_nxt;
   logic viol_r, viol_nxt;
   logic busy_r, busy_nxt;
   logic mem_we;
   fbp_waddr_t mem_wa;
   fbp_word_t mem_wd;
   logic erase_go, pgm_go, cmd_refused, read_refused;

   assign chk_if.fetch_unit = I_FETCH_ADDR[WADDR_W-1:UNIT_LSB];
   assign chk_if.data_unit = I_DATA_ADDR[WADDR_W-1:UNIT_LSB];
   assign chk_if.cmd_unit = I_CMD_ADDR[WADDR_W-1:UNIT_LSB];

   // read ports: registered, so every request is answered on the next edge
   always_comb begin
      fetch_valid_nxt = I_FETCH_REQ;
      fetch_rdata_nxt = fetch_rdata_r;
      if (I_FETCH_REQ) begin
         fetch_rdata_nxt = chk_if.fetch_ok ? mem[I_FETCH_ADDR] : DENY_WORD;
      end
      data_valid_nxt = I_DATA_REQ;
      data_deny_nxt = 1'b0;
      data_rdata_nxt = data_rdata_r;
      read_refused = I_DATA_REQ && !chk_if.data_ok;
      if (I_DATA_REQ) begin
         // debug reads take the same path as processor data reads
         data_deny_nxt = read_refused;
         data_rdata_nxt = chk_if.data_ok ? mem[I_DATA_ADDR] : DENY_WORD;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         fetch_valid_r <= 1'b0;
         fetch_rdata_r <= DENY_WORD;
         data_valid_r <= 1'b0;
         data_deny_r <= 1'b0;
         data_rdata_r <= DENY_WORD;
      end else begin
         fetch_valid_r <= fetch_valid_nxt;
         fetch_rdata_r <= fetch_rdata_nxt;
         data_valid_r <= data_valid_nxt;
         data_deny_r <= data_deny_nxt;
         data_rdata_r <= data_rdata_nxt;
      end
   end

   // erase/program sequencer; commands while busy are dropped without answer
   always_comb begin
      state_nxt = state_r;
      wcnt_nxt = wcnt_r;
      blk_nxt = blk_r;
      done_nxt = 1'b0;
      cdeny_nxt = 1'b0;
      mem_we = 1'b0;
      mem_wa = I_CMD_ADDR;
      mem_wd = ERASED_WORD;
      erase_go = 1'b0;
      pgm_go = 1'b0;
      cmd_refused = 1'b0;
      case (state_r)
         FBP_IDLE: begin
            if (I_CMD_ERASE || I_CMD_PGM) begin
               if (!chk_if.cmd_ok) begin
                  cmd_refused = 1'b1;
                  cdeny_nxt = 1'b1;
               end else if (I_CMD_ERASE) begin
                  erase_go = 1'b1;
                  blk_nxt = I_CMD_ADDR[WADDR_W-1:BLK_LSB];
                  wcnt_nxt = WCNT_RST;
                  state_nxt = FBP_ERASE;
               end else begin
                  // programming can only clear bits, like real cells
                  pgm_go = 1'b1;
                  mem_we = 1'b1;
                  mem_wd = mem[I_CMD_ADDR] & I_CMD_WDATA;
                  done_nxt = 1'b1;
               end
            end
         end
         FBP_ERASE: begin
            mem_we = 1'b1;
            mem_wa = {blk_r, wcnt_r};
            mem_wd = ERASED_WORD;
            wcnt_nxt = WCNT_W'(wcnt_r + 8'h01);
            if (wcnt_r == WCNT_LAST) begin
               state_nxt = FBP_IDLE;
               done_nxt = 1'b1;
            end
         end
         default: begin
            state_nxt = FBP_IDLE;
         end
      endcase
      // a new denial in the clearing cycle still leaves the flag set
      viol_nxt = (viol_r && !I_VIOL_CLR) || cmd_refused || read_refused;
      // busy kept in its own flop so the pin has no decode behind it
      busy_nxt = (state_nxt == FBP_ERASE);
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         state_r <= FBP_IDLE;
         wcnt_r <= WCNT_RST;
         blk_r <= '0;
         done_r <= 1'b0;
         cdeny_r <= 1'b0;
         viol_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         wcnt_r <= wcnt_nxt;
         blk_r <= blk_nxt;
         done_r <= done_nxt;
         cdeny_r <= cdeny_nxt;
         viol_r <= viol_nxt;
         busy_r <= busy_nxt;
      end
   end

   // the array itself is never reset: its contents are nonvolatile
   always_ff @(posedge I_CLK) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign O_FETCH_VALID = fetch_valid_r;
   assign O_FETCH_RDATA = fetch_rdata_r;
   assign O_DATA_VALID = data_valid_r;
   assign O_DATA_DENY = data_deny_r;
   assign O_DATA_RDATA = data_rdata_r;
   assign O_BUSY = busy_r;
   assign O_CMD_DONE = done_r;
   assign O_CMD_DENY = cdeny_r;
   assign O_VIOLATION = viol_r;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   sequence s_erase_start;
      erase_go;
   endsequence

   sequence s_erase_run;
      O_BUSY [*8] ##248 O_BUSY ##1 (!O_BUSY && O_CMD_DONE);
   endsequence

   fetch_latency_a: assert property (I_FETCH_REQ |=> O_FETCH_VALID
      && O_FETCH_RDATA == $past(mem[I_FETCH_ADDR]))
      else $error("fetch not answered next cycle with array word");
   xo_data_deny_a: assert property (I_DATA_REQ && I_PROT_XO[I_DATA_ADDR[14:9]]
      |=> O_DATA_VALID && O_DATA_DENY && O_DATA_RDATA == DENY_WORD)
      else $error("execute-only word leaked to a data read");
   ro_read_ok_a: assert property (I_DATA_REQ && !I_PROT_XO[I_DATA_ADDR[14:9]]
      |=> O_DATA_VALID && !O_DATA_DENY)
      else $error("readable unit denied to a data read");
   erase_length_a: assert property (s_erase_start |=> s_erase_run)
      else $error("erase did not take exactly 256 word cycles");
   erase_ones_a: assert property (O_BUSY && mem_we
      |-> mem_wd == ERASED_WORD && mem_wa[14:8] == blk_r)
      else $error("erase wrote outside its block or not all ones");
   ro_cmd_deny_a: assert property ((I_CMD_ERASE || I_CMD_PGM) && !O_BUSY
      && I_PROT_RO[I_CMD_ADDR[14:9]] |-> !mem_we ##1 (O_CMD_DENY && !O_BUSY))
      else $error("read-only unit accepted erase or program");
   xo_cmd_deny_a: assert property ((I_CMD_ERASE || I_CMD_PGM) && !O_BUSY
      && I_PROT_XO[I_CMD_ADDR[14:9]] |-> !mem_we ##1 (O_CMD_DENY && !O_CMD_DONE))
      else $error("execute-only unit accepted erase or program");
   viol_sticky_a: assert property ((cmd_refused || read_refused) |=> O_VIOLATION
      ##1 (O_VIOLATION || $past(I_VIOL_CLR)))
      else $error("violation flag lost or not set");
   unit_span_a: assert property ((I_CMD_ERASE || I_CMD_PGM) && !O_BUSY
      && !I_PROT_RO[I_CMD_ADDR[14:9]] && !I_PROT_XO[I_CMD_ADDR[14:9]] |=> !O_CMD_DENY)
      else $error("command refused by the setting of another unit");
   pgm_done_a: assert property (pgm_go |=> O_CMD_DONE && !O_CMD_DENY && !O_BUSY)
      else $error("open program not finished next cycle");
endmodule : fbp_top

// >>> dv/fbp_host_model.sv
// processor fetch and data/debugger read requester
`timescale 1ns/1ps
module fbp_host_model (
   input wire logic i_clk,
   output logic o_fetch_req,
   output fbp_pkg::fbp_waddr_t o_fetch_addr,
   input wire logic i_fetch_valid,
   input wire fbp_pkg::fbp_word_t i_fetch_rdata,
   output logic o_data_req,
   output logic o_data_dbg,
   output fbp_pkg::fbp_waddr_t o_data_addr,
   input wire logic i_data_valid,
   input wire logic i_data_deny,
   input wire fbp_pkg::fbp_word_t i_data_rdata
);
   import fbp_pkg::*;
   initial begin
      o_fetch_req = 1'h0;
      o_fetch_addr = '0;
      o_data_req = 1'h0;
      o_data_dbg = 1'h0;
      o_data_addr = '0;
   end
   // one read; the answer is taken on the very next edge, no wait states
   task automatic rd(input logic fe, input logic dbg, input fbp_waddr_t a,
         output logic v, output logic dn, output fbp_word_t d);
      @(posedge i_clk);
      #1;
      o_fetch_req = fe;
      o_fetch_addr = a;
      o_data_req = ~fe;
      o_data_dbg = dbg;
      o_data_addr = a;
      @(posedge i_clk);
      #1;
      o_fetch_req = 1'h0;
      o_data_req = 1'h0;
      // idle address lines carry junk, never the last value
      o_fetch_addr = ~a;
      o_data_addr = ~a;
      v = fe ? i_fetch_valid : i_data_valid;
      dn = fe ? 1'h0 : i_data_deny;
      d = fe ? i_fetch_rdata : i_data_rdata;
   endtask : rd
endmodule : fbp_host_model

// >>> dv/test_flash_block_protection.sv
// self-checking bench for the flash block protection top
`timescale 1ns/1ps
module test_flash_block_protection;
   import fbp_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   fbp_umask_t ro = '0;
   fbp_umask_t xo = '0;
   logic f_req, f_val, d_req, d_dbg, d_val, d_deny, busy, done, deny, viol;
   fbp_waddr_t f_addr, d_addr;
   fbp_word_t f_data, d_data;
   logic er = 1'h0;
   logic pg = 1'h0;
   logic vclr = 1'h0;
   fbp_waddr_t c_addr = '0;
   fbp_word_t c_wdata = '0;
   int n_mismatch = 0;
   int checks_done = 0;
   always #5 clk = ~clk;
   fbp_top dut_u (.I_CLK(clk), .I_RESET(rst), .I_PROT_RO(ro), .I_PROT_XO(xo),
      .I_FETCH_REQ(f_req), .I_FETCH_ADDR(f_addr), .O_FETCH_VALID(f_val),
      .O_FETCH_RDATA(f_data), .I_DATA_REQ(d_req), .I_DATA_DBG(d_dbg),
      .I_DATA_ADDR(d_addr), .O_DATA_VALID(d_val), .O_DATA_DENY(d_deny),
      .O_DATA_RDATA(d_data), .I_CMD_ERASE(er), .I_CMD_PGM(pg), .I_CMD_ADDR(c_addr),
      .I_CMD_WDATA(c_wdata), .O_BUSY(busy), .O_CMD_DONE(done), .O_CMD_DENY(deny),
      .I_VIOL_CLR(vclr), .O_VIOLATION(viol));
   fbp_host_model hm_u (.i_clk(clk), .o_fetch_req(f_req), .o_fetch_addr(f_addr),
      .i_fetch_valid(f_val), .i_fetch_rdata(f_data), .o_data_req(d_req),
      .o_data_dbg(d_dbg), .o_data_addr(d_addr), .i_data_valid(d_val),
      .i_data_deny(d_deny), .i_data_rdata(d_data));
   task automatic chk_w(input fbp_word_t got, input fbp_word_t exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk_w
   task automatic chk_b(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk_b
   task automatic rd_chk(input logic fe, input logic dbg, input fbp_waddr_t a,
         input logic dny, input fbp_word_t exp);
      logic v, dn;
      fbp_word_t d;
      hm_u.rd(fe, dbg, a, v, dn, d);
      chk_b(v, 1'h1);
      chk_b(dn, dny);
      chk_w(d, exp);
   endtask : rd_chk
   // busy cycles are counted so a short or long erase shows up
   task automatic cmd_chk(input logic e, input fbp_waddr_t a, input fbp_word_t d,
         input logic x_done, input int x_busy);
      int nb;
      nb = 0;
      @(posedge clk);
      #1;
      er = e;
      pg = ~e;
      c_addr = a;
      c_wdata = d;
      @(posedge clk);
      #1;
      er = 1'h0;
      pg = 1'h0;
      c_addr = ~a;
      c_wdata = ~d;
      for (int k = 0; k < 300 && done !== 1'h1 && deny !== 1'h1; k++) begin
         nb = nb + int'(busy === 1'h1);
         @(posedge clk);
         #1;
      end
      chk_b(done, x_done);
      chk_b(deny, ~x_done);
      chk_w(fbp_word_t'(nb), fbp_word_t'(x_busy));
   endtask : cmd_chk
   task automatic t_erase();
      fbp_waddr_t blk[4] = '{15'h0000, 15'h0100, 15'h0200, 15'h7F00};
      for (int i = 0; i < 4; i++) begin
         cmd_chk(1'h1, blk[i], '0, 1'h1, 256);
      end
      cmd_chk(1'h0, 15'h0100, 32'h12345678, 1'h1, 0);
      cmd_chk(1'h1, 15'h0000, '0, 1'h1, 256);
      rd_chk(1'h0, 1'h0, 15'h0100, 1'h0, 32'h12345678);
      rd_chk(1'h0, 1'h0, 15'h00FF, 1'h0, ERASED_WORD);
      rd_chk(1'h1, 1'h0, 15'h7FFF, 1'h0, ERASED_WORD);
      $display("test erase done");
   endtask : t_erase
   task automatic t_ro();
      ro = fbp_umask_t'(1);
      cmd_chk(1'h0, 15'h0100, 32'h00000000, 1'h0, 0);
      cmd_chk(1'h1, 15'h0000, '0, 1'h0, 0);
      @(posedge clk);
      #1;
      chk_b(viol, 1'h1);
      rd_chk(1'h0, 1'h1, 15'h0100, 1'h0, 32'h12345678);
      rd_chk(1'h1, 1'h0, 15'h0100, 1'h0, 32'h12345678);
      vclr = 1'h1;
      @(posedge clk);
      #1;
      vclr = 1'h0;
      chk_b(viol, 1'h0);
      ro = '0;
      $display("test read-only done");
   endtask : t_ro
   task automatic t_xo();
      xo = fbp_umask_t'(1);
      cmd_chk(1'h1, 15'h0100, '0, 1'h0, 0);
      rd_chk(1'h0, 1'h0, 15'h0100, 1'h1, DENY_WORD);
      rd_chk(1'h0, 1'h1, 15'h0101, 1'h1, DENY_WORD);
      rd_chk(1'h1, 1'h0, 15'h0100, 1'h0, 32'h12345678);
      cmd_chk(1'h0, 15'h0200, 32'h0F0F00F0, 1'h1, 0);
      rd_chk(1'h0, 1'h0, 15'h0200, 1'h0, 32'h0F0F00F0);
      chk_b(viol, 1'h1);
      xo = '0;
      $display("test execute-only done");
   endtask : t_xo
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (16) @(posedge clk);
      #1;
      rst = 1'h0;
      chk_b(busy, 1'h0);
      chk_b(viol, 1'h0);
      t_erase();
      t_ro();
      t_xo();
      complete_run();
   end
   // the tests need about 1340 cycles; allow ample margin
   initial begin
      #100000;
      n_mismatch++;
      complete_run();
   end
endmodule : test_flash_block_protection
